/* hw/paged_control_register_bank.sv */
// Paged control register bank shared by the serial and two-wire control ports
`timescale 1ns/1ns
// Notes on behaviour
// - every register holds one byte
// - pages of 128 registers, 7-bit offset
// - page 0 after reset and soft reset
// - page 1 shows live status and diagnostics
// - coefficients live only in pages 2-4
// - offset 0 is page select in every page
// - writing N to offset 0 selects page N
// - page-0 registers load defaults on reset
// - both control ports share one page mechanism
// - 7-bit offset then direction bit per access
// - sequential bytes go to consecutive offsets
module paged_control_register_bank #(
	parameter int STATUS_REGS = 16
) (
	input  wire logic                      clk_i,
	input  wire logic                      reset_i,
	input  wire reg_bank_pkg::port_req_t   i2c_req_i,
	input  wire reg_bank_pkg::port_req_t   spi_req_i,
	input  wire logic [7:0]                clk_monitor_status_i,
	input  wire logic [STATUS_REGS*8-1:0]  live_status_i,
	output reg_bank_pkg::port_rsp_t        i2c_rsp_o,
	output reg_bank_pkg::port_rsp_t        spi_rsp_o,
	output reg_bank_pkg::config_image_t    config_o,
	output logic [7:0]                     active_page_o,
	output logic                           soft_reset_pulse_o
);

	localparam int COEF_AW = $clog2(reg_bank_pkg::COEF_PAGES *
		reg_bank_pkg::PAGE_REGS);

	typedef enum logic [1:0] {
		SRC_IDLE = 2'b00,
		SRC_I2C  = 2'b01,
		SRC_SPI  = 2'b11
	} source_t;

	typedef struct packed {
		source_t                      owner;
		logic [6:0]                   offset;
		logic [7:0]                   page;
		reg_bank_pkg::config_image_t  cfg;
		logic [7:0]                   soft_reg;
		logic                         soft_pulse;
		reg_bank_pkg::port_rsp_t      i2c_rsp;
		reg_bank_pkg::port_rsp_t      spi_rsp;
	} bank_state_t;

	bank_state_t st_q;
	bank_state_t st_d;

	reg_bank_pkg::port_req_t req;
	logic [6:0]              acc_off;
	logic                    is_coef;
	logic                    coef_wr;
	logic [COEF_AW-1:0]      coef_addr;
	logic [7:0]              coef_rdata;
	logic [7:0]              rd_byte;

	// Page number to linear coefficient address
	function automatic logic [COEF_AW-1:0] coef_index(
		input logic [7:0] page,
		input logic [6:0] off
	);
		logic [7:0] rel;
		rel = page - reg_bank_pkg::PAGE_COEF_FIRST;
		coef_index = COEF_AW'({rel, off});
	endfunction : coef_index

	function automatic logic in_coef_pages(input logic [7:0] page);
		in_coef_pages = (page >= reg_bank_pkg::PAGE_COEF_FIRST) &&
			(page <= reg_bank_pkg::PAGE_COEF_LAST);
	endfunction : in_coef_pages

	// Port arbitration per byte: the two-wire port is taken in any cycle it
	// strobes start or valid. Simultaneous frames are not expected, the two-wire port wins.
	always_comb begin
		if (i2c_req_i.start || i2c_req_i.valid) begin
			req = i2c_req_i;
		end else begin
			req = spi_req_i;
		end
	end

	// Start byte supplies the offset; later bytes use the running offset
	assign acc_off = req.start ? req.offset : st_q.offset;
	assign is_coef = in_coef_pages(st_q.page);
	assign coef_wr = req.valid && req.write && is_coef &&
		(acc_off != reg_bank_pkg::OFF_PAGE_SELECT);
	assign coef_addr = coef_index(st_q.page, acc_off);

	coef_store #(
		.PAGES (reg_bank_pkg::COEF_PAGES),
		.REGS  (reg_bank_pkg::PAGE_REGS)
	) u_coef (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.wr_i    (coef_wr),
		.addr_i  (coef_addr),
		.wdata_i (req.wdata),
		.rdata_o (coef_rdata)
	);

	// Read decode for the active page
	always_comb begin
		rd_byte = reg_bank_pkg::READ_ZERO;
		if (acc_off == reg_bank_pkg::OFF_PAGE_SELECT) begin
			rd_byte = st_q.page;
		end else if (st_q.page == reg_bank_pkg::PAGE_CONFIG) begin
			unique case (acc_off)
				reg_bank_pkg::OFF_SOFT_RESET:
					rd_byte = st_q.soft_reg;
				reg_bank_pkg::OFF_SLEEP:
					rd_byte = st_q.cfg.sleep;
				reg_bank_pkg::OFF_SHUTDOWN:
					rd_byte = st_q.cfg.shutdown;
				reg_bank_pkg::OFF_ASI_A:
					rd_byte = st_q.cfg.asi_a;
				reg_bank_pkg::OFF_ASI_B:
					rd_byte = st_q.cfg.asi_b;
				reg_bank_pkg::OFF_ASI_C:
					rd_byte = st_q.cfg.asi_c;
				reg_bank_pkg::OFF_CH1_SLOT:
					rd_byte = st_q.cfg.ch1_slot;
				reg_bank_pkg::OFF_CH2_SLOT:
					rd_byte = st_q.cfg.ch2_slot;
				reg_bank_pkg::OFF_MASTER_A:
					rd_byte = st_q.cfg.master_a;
				reg_bank_pkg::OFF_MASTER_B:
					rd_byte = st_q.cfg.master_b;
				reg_bank_pkg::OFF_CLK_MON_STATUS:
					rd_byte = clk_monitor_status_i;
				reg_bank_pkg::OFF_CLK_SOURCE:
					rd_byte = st_q.cfg.clk_source;
				reg_bank_pkg::OFF_PIN_FUNC_A:
					rd_byte = st_q.cfg.pin_func_a;
				default:
					rd_byte = reg_bank_pkg::READ_ZERO;
			endcase
		end else if (st_q.page == reg_bank_pkg::PAGE_STATUS) begin
			// Status bytes from offset 1 upward, live from the inputs
			if (acc_off != reg_bank_pkg::OFF_PAGE_SELECT &&
				int'(acc_off) <= STATUS_REGS) begin
				rd_byte = live_status_i[(int'(acc_off) - 1) *
					reg_bank_pkg::DATA_W +: reg_bank_pkg::DATA_W];
			end
		end else if (is_coef) begin
			rd_byte = coef_rdata;
		end
	end

	always_comb begin
		st_d = st_q;
		st_d.soft_pulse = 1'b0;
		st_d.i2c_rsp.valid = 1'b0;
		st_d.spi_rsp.valid = 1'b0;
		if (req.start) begin
			st_d.owner = (i2c_req_i.start || i2c_req_i.valid) ?
				SRC_I2C : SRC_SPI;
			st_d.offset = req.offset;
		end
		if (req.valid) begin
			if (req.write) begin
				if (acc_off == reg_bank_pkg::OFF_PAGE_SELECT) begin
					// New page governs the very next byte
					st_d.page = req.wdata;
				end else if (st_q.page == reg_bank_pkg::PAGE_CONFIG) begin
					unique case (acc_off)
						reg_bank_pkg::OFF_SOFT_RESET: begin
							st_d.soft_reg = req.wdata;
						end
						reg_bank_pkg::OFF_SLEEP:
							st_d.cfg.sleep = req.wdata;
						reg_bank_pkg::OFF_SHUTDOWN:
							st_d.cfg.shutdown = req.wdata;
						reg_bank_pkg::OFF_ASI_A:
							st_d.cfg.asi_a = req.wdata;
						reg_bank_pkg::OFF_ASI_B:
							st_d.cfg.asi_b = req.wdata;
						reg_bank_pkg::OFF_ASI_C:
							st_d.cfg.asi_c = req.wdata;
						reg_bank_pkg::OFF_CH1_SLOT:
							st_d.cfg.ch1_slot = req.wdata;
						reg_bank_pkg::OFF_CH2_SLOT:
							st_d.cfg.ch2_slot = req.wdata;
						reg_bank_pkg::OFF_MASTER_A:
							st_d.cfg.master_a = req.wdata;
						reg_bank_pkg::OFF_MASTER_B:
							st_d.cfg.master_b = req.wdata;
						reg_bank_pkg::OFF_CLK_SOURCE:
							st_d.cfg.clk_source = req.wdata;
						reg_bank_pkg::OFF_PIN_FUNC_A:
							st_d.cfg.pin_func_a = req.wdata;
						default: begin
							// Status and unlisted offsets ignore writes
						end
					endcase
				end
			end else begin
				// Owner already reflects this byte's start strobe
				if (st_d.owner == SRC_SPI && !i2c_req_i.valid) begin
					st_d.spi_rsp.valid = 1'b1;
					st_d.spi_rsp.rdata = rd_byte;
				end else begin
					st_d.i2c_rsp.valid = 1'b1;
					st_d.i2c_rsp.rdata = rd_byte;
				end
			end
			st_d.offset = acc_off + 7'h01;
		end
		// Self-clearing trigger: the written bit fires one pulse
		if (st_q.soft_reg[reg_bank_pkg::SOFT_RESET_BIT]) begin
			st_d = st_q;
			st_d.page = reg_bank_pkg::PAGE_CONFIG;
			st_d.cfg = reg_bank_pkg::CONFIG_RESET;
			st_d.soft_reg = reg_bank_pkg::RST_SOFT_RESET;
			st_d.soft_pulse = 1'b1;
			st_d.i2c_rsp.valid = 1'b0;
			st_d.spi_rsp.valid = 1'b0;
		end
		if (reset_i) begin
			st_d.owner = SRC_IDLE;
			st_d.offset = reg_bank_pkg::OFF_PAGE_SELECT;
			st_d.page = reg_bank_pkg::RST_PAGE_SELECT;
			st_d.cfg = reg_bank_pkg::CONFIG_RESET;
			st_d.soft_reg = reg_bank_pkg::RST_SOFT_RESET;
			st_d.soft_pulse = 1'b0;
			st_d.i2c_rsp = '0;
			st_d.spi_rsp = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	assign i2c_rsp_o = st_q.i2c_rsp;
	assign spi_rsp_o = st_q.spi_rsp;
	assign config_o = st_q.cfg;
	assign active_page_o = st_q.page;
	assign soft_reset_pulse_o = st_q.soft_pulse;

endmodule : paged_control_register_bank

/* pkg/reg_bank_pkg.sv */
// Shared constants and carrier types for the paged control register bank
package reg_bank_pkg;

	localparam int DATA_W  = 8;
	localparam int OFFS_W  = 7;
	localparam int PAGE_REGS = 128;

	// Page numbers
	localparam logic [7:0] PAGE_CONFIG = 8'h00;
	localparam logic [7:0] PAGE_STATUS = 8'h01;
	localparam logic [7:0] PAGE_COEF_FIRST = 8'h02;
	localparam logic [7:0] PAGE_COEF_LAST  = 8'h04;
	localparam int COEF_PAGES = 3;

	// Page-0 offsets
	localparam logic [6:0] OFF_PAGE_SELECT     = 7'h00;
	localparam logic [6:0] OFF_SOFT_RESET      = 7'h01;
	localparam logic [6:0] OFF_SLEEP           = 7'h02;
	localparam logic [6:0] OFF_SHUTDOWN        = 7'h05;
	localparam logic [6:0] OFF_ASI_A           = 7'h07;
	localparam logic [6:0] OFF_ASI_B           = 7'h08;
	localparam logic [6:0] OFF_ASI_C           = 7'h09;
	localparam logic [6:0] OFF_CH1_SLOT        = 7'h0B;
	localparam logic [6:0] OFF_CH2_SLOT        = 7'h0C;
	localparam logic [6:0] OFF_MASTER_A        = 7'h13;
	localparam logic [6:0] OFF_MASTER_B        = 7'h14;
	localparam logic [6:0] OFF_CLK_MON_STATUS  = 7'h15;
	localparam logic [6:0] OFF_CLK_SOURCE      = 7'h16;
	localparam logic [6:0] OFF_PIN_FUNC_A      = 7'h21;

	// Reset values
	localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
	localparam logic [7:0] RST_SOFT_RESET  = 8'h00;
	localparam logic [7:0] RST_SLEEP       = 8'h00;
	localparam logic [7:0] RST_SHUTDOWN    = 8'h05;
	localparam logic [7:0] RST_ASI_A       = 8'h30;
	localparam logic [7:0] RST_ASI_B       = 8'h00;
	localparam logic [7:0] RST_ASI_C       = 8'h00;
	localparam logic [7:0] RST_CH1_SLOT    = 8'h00;
	localparam logic [7:0] RST_CH2_SLOT    = 8'h01;
	localparam logic [7:0] RST_MASTER_A    = 8'h02;
	localparam logic [7:0] RST_MASTER_B    = 8'h48;
	localparam logic [7:0] RST_CLK_SOURCE  = 8'h10;
	localparam logic [7:0] RST_PIN_FUNC_A  = 8'h22;
	localparam logic [7:0] RST_COEF        = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;

	// Soft reset trigger bit inside soft_reset_control
	localparam int SOFT_RESET_BIT = 0;

	// Byte access arriving from one control port
	typedef struct packed {
		logic       start;   // first byte of a frame carries the offset
		logic       valid;   // data byte strobe
		logic       write;   // direction: 1 write, 0 read
		logic [6:0] offset;  // offset, sampled with start
		logic [7:0] wdata;
	} port_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} port_rsp_t;

	// Page-0 configuration image
	typedef struct packed {
		logic [7:0] sleep;
		logic [7:0] shutdown;
		logic [7:0] asi_a;
		logic [7:0] asi_b;
		logic [7:0] asi_c;
		logic [7:0] ch1_slot;
		logic [7:0] ch2_slot;
		logic [7:0] master_a;
		logic [7:0] master_b;
		logic [7:0] clk_source;
		logic [7:0] pin_func_a;
	} config_image_t;

	localparam config_image_t CONFIG_RESET = '{
		sleep:      RST_SLEEP,
		shutdown:   RST_SHUTDOWN,
		asi_a:      RST_ASI_A,
		asi_b:      RST_ASI_B,
		asi_c:      RST_ASI_C,
		ch1_slot:   RST_CH1_SLOT,
		ch2_slot:   RST_CH2_SLOT,
		master_a:   RST_MASTER_A,
		master_b:   RST_MASTER_B,
		clk_source: RST_CLK_SOURCE,
		pin_func_a: RST_PIN_FUNC_A
	};

endpackage : reg_bank_pkg

/* hw/coef_store.sv */
// Coefficient byte store covering the coefficient pages
`timescale 1ns/1ns
module coef_store #(
	parameter int PAGES = reg_bank_pkg::COEF_PAGES,
	parameter int REGS  = reg_bank_pkg::PAGE_REGS
) (
	input  wire logic                             clk_i,
	input  wire logic                             reset_i,
	input  wire logic                             wr_i,
	input  wire logic [$clog2(PAGES*REGS)-1:0]    addr_i,
	input  wire logic [reg_bank_pkg::DATA_W-1:0]  wdata_i,
	output logic      [reg_bank_pkg::DATA_W-1:0]  rdata_o
);

	typedef struct packed {
		logic [PAGES*REGS-1:0][reg_bank_pkg::DATA_W-1:0] mem;
	} coef_state_t;

	coef_state_t st_q;
	coef_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (reset_i) begin
			st_d.mem = '{default: reg_bank_pkg::RST_COEF};
		end else if (wr_i) begin
			st_d.mem[addr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		st_q <= st_d;
	end

	// Combinational read; the bank registers the byte
	assign rdata_o = st_q.mem[addr_i];

endmodule : coef_store

/* dv/paged_control_register_bank_sva.sv */
// Port assertions for the paged control register bank
`timescale 1ns/1ns
module paged_control_register_bank_sva #(
	parameter int STATUS_REGS = 16
) (
	input wire logic                        clk_i,
	input wire logic                        reset_i,
	input wire reg_bank_pkg::port_req_t     i2c_req_i,
	input wire reg_bank_pkg::port_req_t     spi_req_i,
	input wire logic [7:0]                  clk_monitor_status_i,
	input wire logic [STATUS_REGS*8-1:0]    live_status_i,
	input wire reg_bank_pkg::port_rsp_t     i2c_rsp_o,
	input wire reg_bank_pkg::port_rsp_t     spi_rsp_o,
	input wire reg_bank_pkg::config_image_t config_o,
	input wire logic [7:0]                  active_page_o,
	input wire logic                        soft_reset_pulse_o
);
	wire logic wr_any = i2c_req_i.valid & i2c_req_i.write
		| spi_req_i.valid & spi_req_i.write;
	wire logic wr_st = i2c_req_i.valid & i2c_req_i.write & i2c_req_i.start;
	wire logic rd_i = i2c_req_i.valid & ~i2c_req_i.write;
	wire logic spi_wr = spi_req_i.valid & spi_req_i.write & spi_req_i.start
		& ~i2c_req_i.valid;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	reset_state_a: assert property ($fell(reset_i) |-> active_page_o == 8'h00
		&& config_o == reg_bank_pkg::CONFIG_RESET) else $error("reset state");
	read_answer_a: assert property (rd_i |=> i2c_rsp_o.valid)
		else $error("read not answered");
	rsp_cause_a: assert property (i2c_rsp_o.valid |-> $past(rd_i))
		else $error("answer without read");
	page_write_a: assert property (wr_st && i2c_req_i.offset == 7'h00
		|=> active_page_o == $past(i2c_req_i.wdata)) else $error("page write");
	page_hold_a: assert property (!wr_any
		|=> $stable(active_page_o) || soft_reset_pulse_o) else $error("page moved");
	cfg_write_a: assert property (spi_wr && spi_req_i.offset == 7'h05
		&& active_page_o == 8'h00 |=> config_o.shutdown == $past(spi_req_i.wdata))
		else $error("shutdown write");
	soft_fire_a: assert property (wr_st && i2c_req_i.offset == 7'h01
		&& i2c_req_i.wdata[0] && active_page_o == 8'h00 |-> ##2 soft_reset_pulse_o)
		else $error("soft reset not fired");
	soft_state_a: assert property (soft_reset_pulse_o |-> active_page_o == 8'h00
		&& config_o == reg_bank_pkg::CONFIG_RESET) else $error("soft reset state");
	status_read_a: assert property (rd_i && i2c_req_i.start
		&& i2c_req_i.offset == 7'h15 && active_page_o == 8'h00
		|=> i2c_rsp_o.rdata == $past(clk_monitor_status_i)) else $error("status");
	cover property (soft_reset_pulse_o);
	cover property (i2c_rsp_o.valid);
	cover property (wr_any ##1 active_page_o == 8'h02);
endmodule : paged_control_register_bank_sva

bind paged_control_register_bank paged_control_register_bank_sva #(
	.STATUS_REGS(STATUS_REGS)) chk (.clk_i(clk_i), .reset_i(reset_i),
	.i2c_req_i(i2c_req_i), .spi_req_i(spi_req_i), .config_o(config_o),
	.clk_monitor_status_i(clk_monitor_status_i), .live_status_i(live_status_i),
	.i2c_rsp_o(i2c_rsp_o), .spi_rsp_o(spi_rsp_o), .active_page_o(active_page_o),
	.soft_reset_pulse_o(soft_reset_pulse_o));

/* dv/host_port_model.sv */
// Host side of one control port: single and sequential byte access
`timescale 1ns/1ns
module host_port_model (
	input  wire logic                    clk_i,
	input  wire reg_bank_pkg::port_rsp_t rsp_i,
	output reg_bank_pkg::port_req_t      req_o
);
	initial req_o = '0;
	// Idle fields flipped so a stale byte is never mistaken for fresh
	task automatic drop();
		@(posedge clk_i);
		#1;
		req_o.valid = 1'b0;
		req_o.start = 1'b0;
		req_o.offset = ~req_o.offset;
		req_o.wdata = ~req_o.wdata;
	endtask : drop
	task automatic wr_seq(input logic [6:0] off, input logic [7:0] d[$]);
		@(posedge clk_i);
		#1;
		req_o.write = 1'b1;
		req_o.start = 1'b1;
		req_o.offset = off;
		foreach (d[i]) begin
			if (i > 0) begin
				@(posedge clk_i);
				#1;
				req_o.start = 1'b0;
			end
			req_o.valid = 1'b1;
			req_o.wdata = d[i];
		end
		drop();
	endtask : wr_seq
	task automatic wr(input logic [6:0] off, input logic [7:0] d);
		wr_seq(off, '{d});
	endtask : wr
	task automatic rd(input logic [6:0] off, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		req_o.write = 1'b0;
		req_o.start = 1'b1;
		req_o.valid = 1'b1;
		req_o.offset = off;
		drop();
		d = rsp_i.valid ? rsp_i.rdata : 8'hXX;
	endtask : rd
endmodule : host_port_model

/* dv/paged_control_register_bank_tb.sv */
// Self-checking bench for the paged control register bank
`timescale 1ns/1ns
module paged_control_register_bank_tb;
	localparam int NS = 4;
	logic                        clk_i = 1'b0;
	logic                        reset_i = 1'b1;
	logic [7:0]                  clk_monitor_status_i = 8'hA5;
	logic [NS*8-1:0]             live_status_i = 32'h44332211;
	reg_bank_pkg::port_req_t     i2c_req_i;
	reg_bank_pkg::port_req_t     spi_req_i;
	reg_bank_pkg::port_rsp_t     i2c_rsp_o;
	reg_bank_pkg::port_rsp_t     spi_rsp_o;
	reg_bank_pkg::config_image_t config_o;
	logic [7:0]                  active_page_o;
	logic                        soft_reset_pulse_o;
	logic [7:0]                  got;
	int                          fails = 0;
	int                          checks = 0;
	int                          cycles = 0;
	logic [6:0] offs [14] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h07, 7'h08, 7'h09,
		7'h0B, 7'h0C, 7'h13, 7'h14, 7'h15, 7'h16, 7'h21};
	logic [7:0] rsts [14] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h30, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h02, 8'h48, 8'hFF, 8'h10, 8'h22};

	paged_control_register_bank #(.STATUS_REGS(NS)) uut (.clk_i(clk_i),
		.reset_i(reset_i), .i2c_req_i(i2c_req_i), .spi_req_i(spi_req_i),
		.clk_monitor_status_i(clk_monitor_status_i),
		.live_status_i(live_status_i), .i2c_rsp_o(i2c_rsp_o),
		.spi_rsp_o(spi_rsp_o), .config_o(config_o),
		.active_page_o(active_page_o), .soft_reset_pulse_o(soft_reset_pulse_o));
	host_port_model h_i2c (.clk_i(clk_i), .rsp_i(i2c_rsp_o), .req_o(i2c_req_i));
	host_port_model h_spi (.clk_i(clk_i), .rsp_i(spi_rsp_o), .req_o(spi_req_i));

	always #2 clk_i = ~clk_i;

	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string name, input logic [7:0] exp,
		input logic [7:0] seen);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic rd_chk(input string name, input logic [6:0] off,
		input logic [7:0] exp);
		h_i2c.rd(off, got);
		check(name, exp, got);
	endtask : rd_chk

	// Ceiling well above the roughly 150 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (10) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		for (int i = 0; i < 14; i++)
			rd_chk("reset value", offs[i], i == 11 ? 8'hA5 : rsts[i]);
		for (int i = 1; i < 14; i++)
			h_spi.wr(offs[i], rsts[i] ^ 8'hAE);
		clk_monitor_status_i = 8'h3C;
		for (int i = 1; i < 14; i++)
			rd_chk("rw value", offs[i], i == 11 ? 8'h3C : rsts[i] ^ 8'hAE);
		h_i2c.wr(7'h03, 8'h5A);
		rd_chk("reserved", 7'h03, 8'h00);
		h_i2c.wr(7'h00, 8'h02);
		check("page", 8'h02, active_page_o);
		h_i2c.wr(7'h10, 8'h3C);
		rd_chk("coef", 7'h10, 8'h3C);
		rd_chk("page field", 7'h00, 8'h02);
		h_spi.wr(7'h00, 8'h03);
		rd_chk("other coef page", 7'h10, 8'h00);
		h_i2c.wr(7'h00, 8'h01);
		rd_chk("live status", 7'h02, 8'h22);
		h_i2c.wr(7'h00, 8'h05);
		h_i2c.wr(7'h10, 8'h77);
		rd_chk("bad page", 7'h10, 8'h00);
		h_i2c.wr(7'h00, 8'h02);
		h_i2c.wr_seq(7'h7F, '{8'h55, 8'h00, 8'h66});
		check("page in burst", 8'h00, active_page_o);
		rd_chk("after page in burst", 7'h01, 8'h66);
		h_i2c.wr(7'h00, 8'h02);
		rd_chk("burst start", 7'h7F, 8'h55);
		h_i2c.wr(7'h00, 8'h00);
		h_i2c.wr(7'h01, 8'h01);
		@(posedge clk_i);
		#1;
		check("soft reset pulse", 8'h01, {7'h00, soft_reset_pulse_o});
		repeat (2) @(posedge clk_i);
		#1;
		check("pulse width", 8'h00, {7'h00, soft_reset_pulse_o});
		check("page after soft reset", 8'h00, active_page_o);
		check("config image", 8'h05, config_o.shutdown);
		rd_chk("shutdown after soft reset", 7'h05, 8'h05);
		h_spi.rd(7'h07, got);
		check("spi read", 8'h30, got);
		// Mid-run reset must also clear the coefficient store
		h_i2c.wr(7'h00, 8'h02);
		reset_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		check("page after reset", 8'h00, active_page_o);
		h_i2c.wr(7'h00, 8'h02);
		rd_chk("coef after reset", 7'h10, 8'h00);
		tally_and_finish();
	end
endmodule : paged_control_register_bank_tb
